// >>> core/atfd_decoder.sv
// Operation
// (RL1) Contiguous mode: A10-A4 ignored, A3-A0 pick register, Fh write reserved.
// (RL2) Both enables low at offset 0: 16-bit word, A0 ignored.
// (RL3) Low-byte enable only at offset 0: even byte then odd byte.
// (RL4) High-byte enable only at offset 0: error read, feature write.
// (RL5) Offsets 8, 9, D duplicate 0 and 1; 9 gives odd byte.
// (RL6) Repeated byte accesses to 8 or 0, or 8-9, step even-odd.
// (RL7) Repeated word accesses to 8, 9 or 0 step buffer words.
// (RL8) Host must not repeat byte accesses to offset 9.
// (RL9) Primary/secondary: 1F/17 selects task file, 3F/37 control registers.
// (RL10) IDE: control select high, task select low, DMA ack high selects.
// (RL11) IDE: both selects high, DMA ack low moves 16-bit DMA data.
// (RL12) Odd register reachable at even address on D15-D8, except 8-bit I/O; high byte at E stays alt status here, not Fh.
// (RL13) IDE width follows register; data may be set to 8-bit.
// (RL14) Word access to offset 1 is treated as data word access.
// (RL15) Dup offsets accept all types; word at D puts error high lane.
// (RL16) Host holds register select low in I/O mode.
// (RL17) Error register holds detail only while status error bit set.
// (RL18) Bit 7 bad block, bit 6 uncorrectable.
// (RL19) Bit 4 sector identifier missing.
// (RL20) Bit 2 command aborted.
// (RL21) Bit 0 general error; bits 5, 3, 1 read zero.
// (RL22) Status error bit set on error end, cleared by next command.
// (RL23) Writes to reserved offset Fh change nothing.
`timescale 1ns/1ps
`default_nettype none
module atfd_decoder
    import atfd_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    // Host pins, asynchronous to clk
    input  wire logic             host_rd_strobe_n,
    input  wire logic             host_wr_strobe_n,
    input  wire logic [9:0]       host_addr,
    input  wire logic             host_reg_sel_n,
    input  wire logic             low_byte_enable_n,
    input  wire logic             high_byte_enable_n,
    input  wire logic             dma_acknowledge_n,
    input  wire logic [15:0]      host_data_in,
    output logic      [15:0]      host_data_out,
    output logic      [1:0]       host_data_oe,
    output logic                  wide_io_indicator_n,
    // Configuration
    input  wire atfd_mode_type    mode,
    input  wire logic             ide_data_8bit,
    // Command engine side
    input  wire atfd_err_evt_type err_evt,
    input  wire logic             cmd_done,
    input  wire logic             cmd_failed,
    input  wire logic [7:0]       status_bits,
    input  wire logic [7:0]       drive_addr_bits,
    output logic                  cmd_valid,
    output logic      [7:0]       cmd_code,
    output logic      [7:0]       dev_ctl,
    // Buffer sides: read words come in, write words go out
    input  wire logic             rbuf_valid,
    output logic                  rbuf_ready,
    input  wire logic [15:0]      rbuf_data,
    output logic                  wbuf_valid,
    input  wire logic             wbuf_ready,
    output logic      [15:0]      wbuf_data
);
    // Register targets after address decode
    typedef enum logic [3:0] {
        T_NONE, T_DATA_W, T_DATA_EVEN, T_DATA_ODD, T_ERR, T_TASK,
        T_ALT, T_DRV
    } atfd_tgt_type;

    typedef struct packed {
        logic [1:0]      rd_s1;
        logic [1:0]      rd_s2;
        logic [1:0]      wr_s1;
        logic [1:0]      wr_s2;
        atfd_access_type acc_s1;
        atfd_access_type acc_s2;
        logic            byte_odd;    // Next buffer byte is odd half
        logic [15:0]     rd_word;     // Word being read out
        logic            rd_word_ok;
        logic [7:0]      wr_even;     // Pending even byte on write
        logic [7:0]      err_bits;
        logic            stat_err;
        logic [7:0]      feature;
        logic [6:2][7:0] task_regs;
        logic [15:0]     dout;
        logic [1:0]      oe;
        logic            wide_n;
        logic            rbuf_rdy;    // Ready leaves a flop
        logic            cmd_valid;
        logic [7:0]      cmd_code;
        logic [7:0]      dev_ctl;
    } atfd_st_type;

    atfd_st_type st_r, st_nxt;
    logic        fifo_in_valid, fifo_in_ready;
    logic [15:0] fifo_in_data;

    // Write words pass a small FIFO; a word written while it is full is dropped
    atfd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (wbuf_valid),
        .out_ready (wbuf_ready),
        .out_data  (wbuf_data)
    );

    // Map an access to its target and the lane it uses
    function automatic atfd_tgt_type decode(
        input atfd_access_type a, input atfd_mode_type m,
        input logic ide8, output logic hi_lane, output logic [3:0] ofs);
        logic word;
        word    = !a.lo_en_n && !a.hi_en_n;
        hi_lane = 1'b0;
        ofs     = a.addr[3:0];
        decode  = T_NONE;
        if (m == ATFD_MODE_IDE) begin
            // lo_en_n carries task select, hi_en_n control select
            if (a.lo_en_n && a.hi_en_n && !a.dma_ack_n) begin
                decode = T_DATA_W;                                 // RL11
            end else if (!a.lo_en_n && a.hi_en_n && a.dma_ack_n) begin
                ofs = {1'b0, a.addr[2:0]};                         // RL10
                decode = (ofs == OFS_DATA) ?
                         (ide8 ? T_DATA_EVEN : T_DATA_W) :         // RL13
                         (ofs == OFS_ERR_FEAT) ? T_ERR : T_TASK;
            end else if (a.lo_en_n && !a.hi_en_n && a.dma_ack_n &&
                         a.addr[2:0] == 3'b110) begin
                ofs = OFS_ALT_CTL;
                decode = T_ALT;                                    // RL10
            end
            return decode;
        end
        if (a.reg_sel_n || (a.lo_en_n && a.hi_en_n)) begin
            return T_NONE;                                         // RL16
        end
        if (m == ATFD_MODE_PRISEC) begin
            if ((a.addr[9:4] == PRI_TASK_HI || a.addr[9:4] == SEC_TASK_HI)
                && !a.addr[3]) begin
                ofs = {1'b0, a.addr[2:0]};                         // RL9
            end else if ((a.addr[9:4] == PRI_CTL_HI ||
                          a.addr[9:4] == SEC_CTL_HI) &&
                         a.addr[2:1] == 2'b11 && !a.addr[3]) begin
                ofs = a.addr[0] ? OFS_DRV_ADDR : OFS_ALT_CTL;      // RL9
            end else begin
                return T_NONE;
            end
        end
        // Contiguous: only A3-A0 matter                            RL1
        if (a.lo_en_n && !ofs[0] && ofs != OFS_DRV_ADDR - 4'h1) begin
            hi_lane = 1'b1;                                        // RL12
            ofs = ofs + 4'h1;
        end else if (a.lo_en_n) begin
            hi_lane = 1'b1;
        end
        unique case (ofs)
            OFS_DATA: decode = word ? T_DATA_W : T_DATA_EVEN;      // RL2 RL3
            OFS_ERR_FEAT: decode = word ? T_DATA_W : T_ERR;        // RL14
            OFS_DUP_EVEN: decode = word ? T_DATA_W : T_DATA_EVEN;  // RL5
            OFS_DUP_ODD: decode = word ? T_DATA_W :
                                  T_DATA_ODD;                      // RL5 RL15
            OFS_DUP_ERR: decode = T_ERR;                           // RL15
            OFS_ALT_CTL: decode = T_ALT;
            OFS_DRV_ADDR: decode = T_DRV;
            4'hA, 4'hB, 4'hC: decode = T_NONE;
            default: decode = T_TASK;
        endcase
        // Offset 0 with high lane only maps to 1 then error      RL4
        // Offset 8 with high lane only maps to 9: odd byte       RL15
        if (hi_lane && !word && (ofs == OFS_DUP_ODD)) begin
            decode = T_DATA_ODD;
        end
    endfunction

    atfd_tgt_type tgt;
    logic         hi_lane, rd_go, wr_go, is_word;
    logic [3:0]   ofs;
    logic [7:0]   rbyte, err_view;

    always_comb begin
        tgt    = decode(st_r.acc_s2, mode, ide_data_8bit, hi_lane, ofs);
        is_word = (mode == ATFD_MODE_IDE) ? (tgt == T_DATA_W) :
                  (!st_r.acc_s2.lo_en_n && !st_r.acc_s2.hi_en_n);
        rd_go  = st_r.rd_s2 == 2'b01;
        wr_go  = st_r.wr_s2 == 2'b01;
        // Detail only while the error flag stands                  RL17
        err_view = st_r.stat_err ? (st_r.err_bits & ERR_LIVE_MASK)
                                 : BYTE_ZERO;                      // RL21
    end

    // Synchronise pins, decode on strobe edges, steer the buffer
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_s1  = {st_r.rd_s1[0], !host_rd_strobe_n};
        st_nxt.rd_s2  = {st_r.rd_s2[0], st_r.rd_s1[1]};
        st_nxt.wr_s1  = {st_r.wr_s1[0], !host_wr_strobe_n};
        st_nxt.wr_s2  = {st_r.wr_s2[0], st_r.wr_s1[1]};
        st_nxt.acc_s1 = '{1'b0, 1'b0, host_addr, host_reg_sel_n,
                          low_byte_enable_n, high_byte_enable_n,
                          dma_acknowledge_n, host_data_in};
        st_nxt.acc_s2 = st_r.acc_s1;
        st_nxt.cmd_valid = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_data  = {8'h00, st_r.wr_even};
        rbyte         = BYTE_ZERO;
        // Prefetch the next read word from the buffer
        if (st_r.rbuf_rdy && rbuf_valid) begin
            st_nxt.rd_word = rbuf_data;
            st_nxt.rd_word_ok = 1'b1;
        end
        // Error events: set wins, next command clears            RL22
        if (st_r.cmd_valid) begin
            st_nxt.stat_err = 1'b0;
            st_nxt.err_bits = BYTE_ZERO;
        end
        st_nxt.err_bits[ERR_BIT_BAD_BLOCK] |= err_evt.bad_block;  // RL18
        st_nxt.err_bits[ERR_BIT_UNCORR]    |= err_evt.uncorr;     // RL18
        st_nxt.err_bits[ERR_BIT_MISSING]   |= err_evt.missing;    // RL19
        st_nxt.err_bits[ERR_BIT_ABORTED]   |= err_evt.aborted;    // RL20
        st_nxt.err_bits[ERR_BIT_GENERAL]   |= err_evt.general;    // RL21
        if (cmd_done && cmd_failed) begin
            st_nxt.stat_err = 1'b1;                                // RL22
        end
        if (st_r.rd_s2[0]) begin
            st_nxt.oe = is_word ? 2'b11 : (hi_lane ? 2'b10 : 2'b01);
        end else begin
            st_nxt.oe = 2'b00;
        end
        // Read side: byte pointer walks even then odd            RL6 RL7
        if (rd_go) begin
            unique case (tgt)
                T_DATA_W: begin
                    st_nxt.dout = st_r.rd_word;                    // RL7
                    st_nxt.rd_word_ok = 1'b0;
                    st_nxt.byte_odd = 1'b0;
                end
                T_DATA_EVEN: begin
                    rbyte = st_r.byte_odd ? st_r.rd_word[15:8]
                                          : st_r.rd_word[7:0];     // RL3
                    st_nxt.dout = {rbyte, rbyte};
                    st_nxt.byte_odd = !st_r.byte_odd;
                    if (st_r.byte_odd) begin
                        st_nxt.rd_word_ok = 1'b0;
                    end
                end
                T_DATA_ODD: begin
                    rbyte = st_r.rd_word[15:8];                    // RL5
                    st_nxt.dout = {rbyte, rbyte};
                    st_nxt.byte_odd = 1'b0;
                    st_nxt.rd_word_ok = 1'b0;                      // RL8
                end
                T_ERR: st_nxt.dout = is_word ? {err_view, st_r.rd_word[7:0]}
                                             : {err_view, err_view}; // RL15
                T_TASK: begin
                    rbyte = (ofs[2:0] == OFS_STAT_CMD[2:0]) ?
                        {status_bits[7:1], st_r.stat_err} :
                        st_r.task_regs[ofs[2:0]];
                    st_nxt.dout = {rbyte, rbyte};
                end
                T_ALT: st_nxt.dout = {2{status_bits[7:1], st_r.stat_err}};
                T_DRV: st_nxt.dout = {drive_addr_bits, drive_addr_bits};
                default: st_nxt.dout = 16'h0000;
            endcase
        end
        // Write side; stalls are the host's to respect via the FIFO
        if (wr_go) begin
            unique case (tgt)
                T_DATA_W: begin
                    fifo_in_valid = 1'b1;                          // RL7
                    fifo_in_data  = st_r.acc_s2.wdata;
                    st_nxt.byte_odd = 1'b0;
                end
                T_DATA_EVEN: begin
                    if (st_r.byte_odd) begin
                        fifo_in_valid = 1'b1;                      // RL6
                        fifo_in_data  = {st_r.acc_s2.wdata[7:0],
                                         st_r.wr_even};
                    end else begin
                        st_nxt.wr_even = st_r.acc_s2.wdata[7:0];
                    end
                    st_nxt.byte_odd = !st_r.byte_odd;
                end
                T_DATA_ODD: begin
                    fifo_in_valid = 1'b1;                          // RL5
                    fifo_in_data  = {hi_lane ? st_r.acc_s2.wdata[15:8]
                                             : st_r.acc_s2.wdata[7:0],
                                     st_r.wr_even};
                    st_nxt.byte_odd = 1'b0;
                end
                T_ERR: st_nxt.feature = hi_lane || is_word ?
                    st_r.acc_s2.wdata[15:8] : st_r.acc_s2.wdata[7:0]; // RL4
                T_TASK: begin
                    rbyte = hi_lane ? st_r.acc_s2.wdata[15:8]
                                    : st_r.acc_s2.wdata[7:0];
                    if (ofs[2:0] == OFS_STAT_CMD[2:0]) begin
                        st_nxt.cmd_valid = 1'b1;
                        st_nxt.cmd_code  = rbyte;
                    end else begin
                        st_nxt.task_regs[ofs[2:0]] = rbyte;
                    end
                end
                T_ALT: st_nxt.dev_ctl = st_r.acc_s2.wdata[7:0];
                default: ;                                         // RL23
            endcase
        end
        // Wide indicator only for word data targets                RL12
        st_nxt.wide_n   = !(tgt == T_DATA_W);
        st_nxt.rbuf_rdy = !st_nxt.rd_word_ok;
    end

    // Full FIFO: word dropped would corrupt data, so host must pace
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.task_regs[OFS_SEC_CNT[2:0]] <= SEC_CNT_RST;
            st_r.wide_n <= 1'b1;
            st_r.acc_s1 <= '1;    // Idle pins, no phantom word access
            st_r.acc_s2 <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign host_data_out       = st_r.dout;
    assign host_data_oe        = st_r.oe;
    assign wide_io_indicator_n = st_r.wide_n;
    assign rbuf_ready          = st_r.rbuf_rdy;
    assign cmd_valid           = st_r.cmd_valid;
    assign cmd_code            = st_r.cmd_code;
    assign dev_ctl             = st_r.dev_ctl;
endmodule
`default_nettype wire

// >>> core/atfd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module atfd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0]   wp;
        logic [AW:0]   rp;
    } atfd_fifo_st_type;

    atfd_fifo_st_type st_r, st_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic full, empty;

    // Extra pointer bit tells full from empty
    assign empty     = st_r.wp == st_r.rp;
    assign full      = (st_r.wp[AW] != st_r.rp[AW]) &&
                       (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[st_r.rp[AW-1:0]];

    // Pointer advance
    always_comb begin
        st_nxt = st_r;
        if (in_valid && !full) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (in_valid && !full) begin
            mem_r[st_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> core/atfd_pkg.sv
package atfd_pkg;

    // Decode modes of the host bus
    typedef enum logic [1:0] {
        ATFD_MODE_CONTIG,
        ATFD_MODE_PRISEC,
        ATFD_MODE_IDE
    } atfd_mode_type;

    // Task file offsets
    localparam logic [3:0] OFS_DATA      = 4'h0;
    localparam logic [3:0] OFS_ERR_FEAT  = 4'h1;
    localparam logic [3:0] OFS_SEC_CNT   = 4'h2;
    localparam logic [3:0] OFS_SEC_NUM   = 4'h3;
    localparam logic [3:0] OFS_CYL_LO    = 4'h4;
    localparam logic [3:0] OFS_CYL_HI    = 4'h5;
    localparam logic [3:0] OFS_CARD_HEAD = 4'h6;
    localparam logic [3:0] OFS_STAT_CMD  = 4'h7;
    localparam logic [3:0] OFS_DUP_EVEN  = 4'h8;
    localparam logic [3:0] OFS_DUP_ODD   = 4'h9;
    localparam logic [3:0] OFS_DUP_ERR   = 4'hD;
    localparam logic [3:0] OFS_ALT_CTL   = 4'hE;
    localparam logic [3:0] OFS_DRV_ADDR  = 4'hF;

    // Upper address fields for primary/secondary decode
    localparam logic [5:0] PRI_TASK_HI = 6'h1F;
    localparam logic [5:0] SEC_TASK_HI = 6'h17;
    localparam logic [5:0] PRI_CTL_HI  = 6'h3F;
    localparam logic [5:0] SEC_CTL_HI  = 6'h37;

    // Error register bit positions
    localparam int ERR_BIT_BAD_BLOCK = 7;
    localparam int ERR_BIT_UNCORR    = 6;
    localparam int ERR_BIT_MISSING   = 4;
    localparam int ERR_BIT_ABORTED   = 2;
    localparam int ERR_BIT_GENERAL   = 0;
    localparam logic [7:0] ERR_LIVE_MASK = 8'hD5;

    // Status register bit positions
    localparam int STAT_BIT_ERR = 0;
    localparam int STAT_BIT_DRQ = 3;
    localparam int STAT_BIT_RDY = 6;

    // Reset values
    localparam logic [7:0] SEC_CNT_RST = 8'h01;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // Host access as sampled after the synchroniser
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic       reg_sel_n;
        logic       lo_en_n;
        logic       hi_en_n;
        logic       dma_ack_n;
        logic [15:0] wdata;
    } atfd_access_type;

    // Error event inputs from the command engine
    typedef struct packed {
        logic bad_block;
        logic uncorr;
        logic missing;
        logic aborted;
        logic general;
    } atfd_err_evt_type;

endpackage

// >>> tb/atfd_buf_model.sv
`timescale 1ns/1ps
`default_nettype none
module atfd_buf_model (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        stall,
    input wire logic        rbuf_ready,
    output logic            rbuf_valid,
    output logic [15:0]     rbuf_data,
    input wire logic        wbuf_valid,
    output logic            wbuf_ready,
    input wire logic [15:0] wbuf_data
);
    logic [3:0]  rd_cnt;
    logic [15:0] got_q[$];
    // Read side never runs dry; word k carries k in both bytes
    assign rbuf_valid = 1'b1;
    assign rbuf_data  = {4'hB, rd_cnt, 4'hA, rd_cnt};
    assign wbuf_ready = !stall;
    // Count fetched words, keep every accepted write word
    always @(posedge clk) begin
        if (srst) rd_cnt <= 4'h0;
        else if (rbuf_ready) rd_cnt <= rd_cnt + 4'h1;
        if (!srst && wbuf_valid && wbuf_ready) got_q.push_back(wbuf_data);
    end
endmodule
`default_nettype wire

// >>> tb/atfd_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module atfd_decoder_tb_top;
    import atfd_pkg::*;
    logic clk = 0, srst = 1, host_rd_strobe_n = 1, host_wr_strobe_n = 1;
    logic low_byte_enable_n = 1, high_byte_enable_n = 1;
    logic dma_acknowledge_n = 1, host_reg_sel_n = 0;
    logic [9:0] host_addr = 10'h000;
    logic [15:0] host_data_in = 16'h0000, host_data_out, wbuf_data, rdat;
    logic [15:0] rbuf_data;
    logic [1:0] host_data_oe;
    logic wide_io_indicator_n, cmd_valid, cmd_done = 0, cmd_failed = 0;
    logic rbuf_valid, rbuf_ready, wbuf_valid, wbuf_ready, stall = 0, ide8 = 0;
    logic [7:0] cmd_code, dev_ctl, status_bits = 8'h40;
    atfd_mode_type mode = ATFD_MODE_CONTIG;
    atfd_err_evt_type err_evt = 5'h00;
    logic [3:0] widx = 4'h0;
    int bad_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    atfd_decoder DUT (.clk, .srst, .host_rd_strobe_n, .host_wr_strobe_n,
        .host_addr, .host_reg_sel_n, .low_byte_enable_n, .high_byte_enable_n,
        .dma_acknowledge_n, .host_data_in, .host_data_out, .host_data_oe,
        .wide_io_indicator_n, .mode, .ide_data_8bit(ide8), .err_evt,
        .cmd_done, .cmd_failed, .status_bits, .drive_addr_bits(8'h3C),
        .cmd_valid, .cmd_code, .dev_ctl, .rbuf_valid, .rbuf_ready,
        .rbuf_data, .wbuf_valid, .wbuf_ready, .wbuf_data);
    atfd_buf_model model (.clk, .srst, .stall, .rbuf_ready, .rbuf_valid,
        .rbuf_data, .wbuf_valid, .wbuf_ready, .wbuf_data);
    function automatic logic [15:0] wexp();
        return {4'hB, widx, 4'hA, widx};
    endfunction
    // One host cycle; strobe held well past the two-stage sync
    task automatic acc(input logic rd, input logic [9:0] a,
                       input logic lo, input logic hi, input logic [15:0] wd);
        @(negedge clk);
        host_addr          = a;
        low_byte_enable_n  = lo;
        high_byte_enable_n = hi;
        host_data_in       = wd;
        @(negedge clk);
        if (rd) host_rd_strobe_n = 1'b0;
        else host_wr_strobe_n = 1'b0;
        repeat (6) @(negedge clk);
        rdat             = host_data_out;
        host_rd_strobe_n = 1'b1;
        host_wr_strobe_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d of %0d compares", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Upper address bits ignored, reserved write harmless
    task automatic t_regs();
        acc(1, 10'h3F2, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h01)
        acc(0, 10'h2A3, 0, 1, 16'h005A);
        acc(0, 10'h00F, 0, 1, 16'h0000);
        acc(0, 10'h00E, 0, 1, 16'h0006);
        `CHK(dev_ctl, 8'h06)
        acc(1, 10'h003, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h5A)
        acc(1, 10'h1CF, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h3C)
    endtask
    // Word, byte pair and duplicate-offset reads walk the buffer
    task automatic t_data();
        acc(1, 10'h3F1, 0, 0, 16'h0);
        `CHK(rdat, wexp())
        widx++;
        acc(1, 10'h000, 0, 1, 16'h0);
        `CHK(rdat[7:0], wexp() & 16'hFF)
        acc(1, 10'h000, 0, 1, 16'h0);
        `CHK(rdat[7:0], wexp() >> 8)
        widx++;
        acc(1, 10'h008, 0, 1, 16'h0);
        `CHK(rdat[7:0], wexp() & 16'hFF)
        acc(1, 10'h009, 0, 1, 16'h0);
        `CHK(rdat[7:0], wexp() >> 8)
        widx++;
        acc(1, 10'h009, 0, 0, 16'h0);
        `CHK(rdat, wexp())
        widx++;
    endtask
    // Failed command exposes error detail until the next command
    task automatic t_error();
        @(negedge clk);
        err_evt    = 5'h1F;
        cmd_done   = 1;
        cmd_failed = 1;
        @(negedge clk);
        err_evt    = 5'h00;
        cmd_done   = 0;
        cmd_failed = 0;
        acc(1, 10'h007, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h41)
        acc(1, 10'h001, 0, 1, 16'h0);
        `CHK(rdat[7:0], ERR_LIVE_MASK)
        acc(1, 10'h000, 1, 0, 16'h0);
        `CHK(rdat[15:8], 8'hD5)
        acc(1, 10'h00D, 0, 0, 16'h0);
        `CHK(rdat[15:8], 8'hD5)
        acc(0, 10'h007, 0, 1, 16'h00EC);
        acc(1, 10'h007, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h40)
        acc(1, 10'h001, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h00)
    endtask
    // Primary/secondary and IDE select decoding, DMA word
    task automatic t_modes();
        mode = ATFD_MODE_PRISEC;
        acc(1, 10'h1F7, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h40)
        acc(1, 10'h376, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h40)
        acc(1, 10'h172, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h01)
        mode = ATFD_MODE_IDE;
        acc(1, 10'h007, 0, 1, 16'h0);
        `CHK(rdat[7:0], 8'h40)
        acc(1, 10'h006, 1, 0, 16'h0);
        `CHK(rdat[7:0], 8'h40)
        dma_acknowledge_n = 0;
        acc(1, 10'h2B5, 1, 1, 16'h0);
        `CHK(rdat, wexp())
        dma_acknowledge_n = 1;
        widx++;
        ide8 = 1;
        acc(1, 10'h000, 0, 1, 16'h0);
        `CHK(rdat[7:0], wexp() & 16'hFF)
        mode = ATFD_MODE_CONTIG;
    endtask
    // Fill the write FIFO while the sink stalls, then drain it
    task automatic t_fifo();
        stall = 1;
        for (int i = 0; i < 5; i++) acc(0, 10'h008, 0, 0, 16'hC0D0 + i);
        `CHK(model.got_q.size(), 0)
        stall = 0;
        for (int i = 0; i < 50 && model.got_q.size() < 4; i++)
            @(negedge clk);
        if (model.got_q.size() < 4) begin
            bad_count++;
            give_verdict();
        end
        repeat (10) @(negedge clk);
        `CHK(model.got_q.size(), 4)
        for (int i = 0; i < 4; i++) `CHK(model.got_q[i], 16'hC0D0 + i)
    endtask
    initial begin
        repeat (6) @(negedge clk);
        srst = 0;
        t_regs();
        t_data();
        t_error();
        t_modes();
        t_fifo();
        give_verdict();
    end
endmodule
bind atfd_decoder atfd_props u_props (.clk, .srst, .host_rd_strobe_n,
    .host_wr_strobe_n, .host_addr, .low_byte_enable_n, .high_byte_enable_n,
    .host_data_in, .host_data_oe, .wide_io_indicator_n, .mode, .cmd_valid,
    .cmd_code, .wbuf_valid, .wbuf_ready, .wbuf_data);
`default_nettype wire

// >>> tb/atfd_props.sv
`timescale 1ns/1ps
`default_nettype none
module atfd_props
    import atfd_pkg::*;
(
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          host_rd_strobe_n,
    input wire logic          host_wr_strobe_n,
    input wire logic [9:0]    host_addr,
    input wire logic          low_byte_enable_n,
    input wire logic          high_byte_enable_n,
    input wire logic [15:0]   host_data_in,
    input wire logic [1:0]    host_data_oe,
    input wire logic          wide_io_indicator_n,
    input wire atfd_mode_type mode,
    input wire logic          cmd_valid,
    input wire logic [7:0]    cmd_code,
    input wire logic          wbuf_valid,
    input wire logic          wbuf_ready,
    input wire logic [15:0]   wbuf_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // A read held past the synchroniser, lane enables given
    sequence rd_held(lo, hi);
        (!host_rd_strobe_n && low_byte_enable_n == lo
         && high_byte_enable_n == hi && mode != ATFD_MODE_IDE)[*5];
    endsequence
    sequence word_rd;
        (!host_rd_strobe_n && !low_byte_enable_n && !high_byte_enable_n
         && mode == ATFD_MODE_CONTIG && host_addr[3:1] == 3'h0)[*5];
    endsequence
    reset_vals_a: assert property ($fell(srst) |-> host_data_oe == 2'h0
        && wide_io_indicator_n && !cmd_valid) else $error("reset state");
    oe_idle_a: assert property (host_rd_strobe_n[*6] |-> host_data_oe == 2'h0)
        else $error("lanes driven without read");
    oe_timely_a: assert property ($fell(host_rd_strobe_n) |->
        ##[2:5] host_data_oe != 2'h0) else $error("read lanes late");
    word_wide_a: assert property (word_rd |-> !wide_io_indicator_n)
        else $error("word access not flagged wide");
    byte_lo_lane_a: assert property (rd_held(1'b0, 1'b1) |->
        host_data_oe == 2'h1) else $error("low lane byte read");
    byte_hi_lane_a: assert property (rd_held(1'b1, 1'b0) |->
        host_data_oe == 2'h2) else $error("high lane byte read");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    cmd_code_a: assert property (cmd_valid |-> !host_wr_strobe_n
        && host_addr[2:0] == 3'h7 && cmd_code == host_data_in[7:0])
        else $error("command code mismatch");
    wbuf_hold_a: assert property (wbuf_valid && !wbuf_ready |=>
        wbuf_valid && $stable(wbuf_data)) else $error("write word moved");
endmodule
`default_nettype wire
